// ==== adc_ctrl_pkg.sv ====
package adc_ctrl_pkg;

    localparam int          CLK_PERIOD_NS   = 100;
    localparam int          CONV_TIME_NS    = 40000;
    localparam int          CONV_CYCLES     = CONV_TIME_NS / CLK_PERIOD_NS;
    localparam int          DONE_READ_NS    = 600;
    localparam int          DONE_READ_CYC   = (DONE_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          RESULT_W        = 8;
    localparam int          CFG_W           = 5;
    localparam int          NUM_CH          = 8;
    localparam int          SAR_STEPS       = 8;
    localparam int          STEP_CYCLES     = CONV_CYCLES / (SAR_STEPS + 2);
    localparam logic [4:0]  CFG_RESET       = 5'h00;
    localparam int          CFG_SE_BIT      = 3;
    localparam int          CFG_PSEUDO_BIT  = 4;
    localparam int          CFG_POL_BIT     = 0;

    typedef enum logic [1:0] {
        MODE_DIFF,
        MODE_SINGLE,
        MODE_PSEUDO
    } mux_mode_t;

    typedef struct packed {
        logic [NUM_CH-1:0] posSel;
        logic [NUM_CH-1:0] negSel;
        logic              negGround;
        mux_mode_t         mode;
    } mux_sel_t;

endpackage

// ==== adc_input_select_and_start_control.sv ====
// Overview of operation
// - config bit3/bit4 pick differential, single, pseudo
// - select plus write loads config, starts conversion
// - select plus read outputs result, reconverts
// - write accepted right after read-started conversion
// - sample plus then minus, half period apart
// - comparator judged at end of period
// - write fall clears done; rise latches config
// - read low through write keeps old config
// - finished result latched, done low; read clears
module adc_input_select_and_start_control
    import adc_ctrl_pkg::*;
(
    input  wire logic                sys_clk,
    input  wire logic                nrst,
    input  wire logic                chipSelect_n,
    input  wire logic                writeStrobe_n,
    input  wire logic                readStrobe_n,
    input  wire logic [RESULT_W-1:0] resultBusIn,
    output logic      [RESULT_W-1:0] resultBusOut,
    output logic      [RESULT_W-1:0] resultBusOe,
    output logic                     conversion_done_n,
    input  wire logic                compareHigh,
    output mux_sel_t                 muxSel,
    output logic                     samplePos,
    output logic                     sampleNeg,
    output logic      [RESULT_W-1:0] dacCode
);

    typedef enum logic [1:0] {
        S_IDLE,
        S_SAMPLE,
        S_APPROX
    } conv_state_t;

    function automatic mux_sel_t decode_cfg(input logic [CFG_W-1:0] cfg);
        mux_sel_t m;
        logic [2:0] idx;
        m   = '0;
        idx = cfg[2:0];
        if (!cfg[CFG_SE_BIT]) begin
            m.mode = MODE_DIFF;
            m.posSel[{cfg[2:1], cfg[CFG_POL_BIT]}]  = 1'b1;
            m.negSel[{cfg[2:1], ~cfg[CFG_POL_BIT]}] = 1'b1;
        end else if (!cfg[CFG_PSEUDO_BIT]) begin
            m.mode          = MODE_SINGLE;
            m.posSel[idx]   = 1'b1;
            m.negGround     = 1'b1;
        end else begin
            m.mode          = MODE_PSEUDO;
            m.posSel[idx]   = 1'b1;
            m.negSel[NUM_CH-1] = 1'b1;
        end
        return m;
    endfunction

    logic        wrAcc, rdAcc, wrAccPrev, rdAccPrev, rdDuringWr_q, rdDuringWr_d;
    logic        wrFall, wrRise, rdFall;
    logic [CFG_W-1:0]    cfg_q, cfg_d;
    logic [CFG_W-1:0]    cfgHold_q, cfgHold_d;
    logic [RESULT_W-1:0] result_q, result_d, sar_q, sar_d;
    logic        done_n_q, done_n_d;
    conv_state_t state_q, state_d;
    logic [9:0]  tick_q, tick_d;
    logic [3:0]  bit_q, bit_d;
    logic        startConv;

    assign wrAcc  = !chipSelect_n && !writeStrobe_n;
    assign rdAcc  = !chipSelect_n && !readStrobe_n;
    assign wrFall = wrAcc && !wrAccPrev;
    assign wrRise = !wrAcc && wrAccPrev;
    assign rdFall = rdAcc && !rdAccPrev;
    // a read-started conversion is simply restarted by a later write
    assign startConv = wrRise || rdFall;

    always_comb begin
        cfg_d        = cfg_q;
        cfgHold_d    = cfgHold_q;
        done_n_d     = done_n_q;
        rdDuringWr_d = rdDuringWr_q;
        if (wrFall)
            rdDuringWr_d = !readStrobe_n;
        else if (wrAcc && readStrobe_n)
            rdDuringWr_d = 1'b0;
        // data lines are taken while the strobe is low; once it is released they may
        // already carry the host's next value
        if (wrAcc)
            cfgHold_d = resultBusIn[CFG_W-1:0];
        if (wrRise && !rdDuringWr_q)
            cfg_d = cfgHold_q;
        if (wrFall || rdFall)
            done_n_d = 1'b1;
        else if (state_q == S_APPROX && tick_q == 10'(STEP_CYCLES - 1) && bit_q == 4'h0)
            done_n_d = 1'b0;
    end

    always_comb begin
        state_d  = state_q;
        tick_d   = tick_q;
        bit_d    = bit_q;
        sar_d    = sar_q;
        result_d = result_q;
        if (startConv) begin
            state_d = S_SAMPLE;
            tick_d  = '0;
            sar_d   = '0;
            bit_d   = 4'(SAR_STEPS - 1);
        end else begin
            unique case (state_q)
                S_IDLE: ;
                S_SAMPLE: begin
                    if (tick_q == 10'(STEP_CYCLES - 1)) begin
                        tick_d  = '0;
                        state_d = S_APPROX;
                        sar_d[bit_q[2:0]] = 1'b1;
                    end else
                        tick_d = tick_q + 10'h001;
                end
                S_APPROX: begin
                    if (tick_q == 10'(STEP_CYCLES - 1)) begin
                        tick_d = '0;
                        // decision taken at the end of the step, after input spikes settle
                        if (!compareHigh)
                            sar_d[bit_q[2:0]] = 1'b0;
                        if (bit_q == 4'h0) begin
                            state_d  = S_IDLE;
                            result_d = compareHigh ? sar_q : (sar_q & ~8'h01);
                        end else begin
                            bit_d = bit_q - 4'h1;
                            sar_d[bit_q[2:0] - 3'h1] = 1'b1;
                        end
                    end else
                        tick_d = tick_q + 10'h001;
                end
                default: state_d = S_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wrAccPrev    <= 1'b0;
            rdAccPrev    <= 1'b0;
            rdDuringWr_q <= 1'b0;
            cfg_q        <= CFG_RESET;
            cfgHold_q    <= CFG_RESET;
            done_n_q     <= 1'b1;
            state_q      <= S_IDLE;
            tick_q       <= '0;
            bit_q        <= '0;
            sar_q        <= '0;
            result_q     <= '0;
        end else begin
            wrAccPrev    <= wrAcc;
            rdAccPrev    <= rdAcc;
            rdDuringWr_q <= rdDuringWr_d;
            cfg_q        <= cfg_d;
            cfgHold_q    <= cfgHold_d;
            done_n_q     <= done_n_d;
            state_q      <= state_d;
            tick_q       <= tick_d;
            bit_q        <= bit_d;
            sar_q        <= sar_d;
            result_q     <= result_d;
        end
    end

    assign conversion_done_n = done_n_q;
    assign resultBusOut      = result_q;
    assign resultBusOe       = {RESULT_W{rdAcc}};
    assign muxSel            = decode_cfg(cfg_q);
    assign dacCode           = sar_q;
    // plus sampled in first half of the sample step, minus half a period later
    assign samplePos = (state_q == S_SAMPLE) && (tick_q < 10'(STEP_CYCLES / 2));
    assign sampleNeg = (state_q == S_SAMPLE) && (tick_q >= 10'(STEP_CYCLES / 2));

    property p_write_loads;
        @(posedge sys_clk) disable iff (!nrst)
        (wrRise && !rdDuringWr_q) |=> cfg_q == $past(resultBusIn[CFG_W-1:0], 2);
    endproperty
    a_write_loads: assert property (p_write_loads) else $error("config not loaded");

    property p_read_restarts;
        @(posedge sys_clk) disable iff (!nrst)
        rdFall |=> state_q == S_SAMPLE && tick_q == 10'h000 && $stable(cfg_q);
    endproperty
    a_read_restarts: assert property (p_read_restarts) else $error("read no restart");

    property p_write_after_read;
        @(posedge sys_clk) disable iff (!nrst)
        (state_q == S_SAMPLE && wrRise) |=> tick_q == 10'h000;
    endproperty
    a_write_after_read: assert property (p_write_after_read) else $error("write refused");

    property p_sample_order;
        @(posedge sys_clk) disable iff (!nrst)
        (samplePos && !sampleNeg) ##1 !samplePos |-> sampleNeg || state_q != S_SAMPLE;
    endproperty
    a_sample_order: assert property (p_sample_order) else $error("sample order");

    property p_fall_clears;
        @(posedge sys_clk) disable iff (!nrst)
        wrFall |=> conversion_done_n;
    endproperty
    a_fall_clears: assert property (p_fall_clears) else $error("done not cleared");

    property p_read_keeps;
        @(posedge sys_clk) disable iff (!nrst)
        (wrRise && rdDuringWr_q) |=> $stable(cfg_q);
    endproperty
    a_read_keeps: assert property (p_read_keeps) else $error("config changed");

    property p_done_time;
        @(posedge sys_clk) disable iff (!nrst)
        startConv ##1 !startConv [*8] |-> ##[0:400] (!conversion_done_n || startConv);
    endproperty
    a_done_time: assert property (p_done_time) else $error("done late");

    property p_decode;
        @(posedge sys_clk) disable iff (!nrst)
        (cfg_q[CFG_SE_BIT] && cfg_q[CFG_PSEUDO_BIT]) |-> muxSel.negSel[NUM_CH-1];
    endproperty
    a_decode: assert property (p_decode) else $error("pseudo decode");

    c_write: cover property (@(posedge sys_clk) disable iff (!nrst) wrRise && !rdDuringWr_q);
    c_read_then_write: cover property (@(posedge sys_clk) disable iff (!nrst)
        rdFall ##[1:20] wrRise);
    c_done: cover property (@(posedge sys_clk) disable iff (!nrst) $fell(conversion_done_n));

endmodule

// ==== adc_bus_host.sv ====
module adc_bus_host
    import adc_ctrl_pkg::*;
(
    input  wire logic                sys_clk,
    input  wire logic [RESULT_W-1:0] rdData,
    input  wire logic [RESULT_W-1:0] rdOe,
    input  wire logic                doneN,
    output logic                     chipSelect_n,
    output logic                     writeStrobe_n,
    output logic                     readStrobe_n,
    output logic      [RESULT_W-1:0] wrData
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        chipSelect_n = 1'b1;
        writeStrobe_n = 1'b1;
        readStrobe_n = 1'b1;
        wrData = 8'h00;
    end

    // strobes held three edges; released lines show the inverse, not the last value
    task automatic access(input logic wr, input logic rd, input logic [7:0] d,
                          output logic [15:0] seen);
        @(posedge sys_clk);
        #10;
        chipSelect_n = 1'b0;
        writeStrobe_n = !wr;
        readStrobe_n = !rd;
        wrData = d;
        repeat (3) @(posedge sys_clk);
        seen = {rdOe, rdData};
        #10;
        chipSelect_n = 1'b1;
        writeStrobe_n = 1'b1;
        readStrobe_n = 1'b1;
        wrData = ~d;
    endtask

    task automatic waitDone(output logic ok);
        ok = 1'b0;
        for (int i = 0; i < 500 && !ok; i++) begin
            @(posedge sys_clk);
            #10;
            ok = (doneN === 1'b0);
        end
        repeat (DONE_READ_CYC) @(posedge sys_clk);
    endtask
endmodule

// ==== adc_input_select_and_start_control_tb.sv ====
module adc_input_select_and_start_control_tb
    import adc_ctrl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic                sys_clk = 1'b0;
    logic                nrst = 1'b0;
    logic                chipSelect_n;
    logic                writeStrobe_n;
    logic                readStrobe_n;
    logic [RESULT_W-1:0] wrData;
    logic [RESULT_W-1:0] resultBusOut;
    logic [RESULT_W-1:0] resultBusOe;
    logic                doneN;
    logic                compareHigh;
    mux_sel_t            muxSel;
    logic [RESULT_W-1:0] dacCode;
    logic                samplePos;
    logic                sampleNeg;
    logic [RESULT_W-1:0] target = 8'hA5;
    logic [15:0]         seen;
    logic                ok;
    int                  n_errors = 0;
    int                  checks = 0;

    // comparator stand-in: a code at or below the input keeps its trial bit
    assign compareHigh = (dacCode <= target);

    initial forever #50 sys_clk = ~sys_clk;

    adc_input_select_and_start_control u_dut (
        .sys_clk(sys_clk), .nrst(nrst), .chipSelect_n(chipSelect_n),
        .writeStrobe_n(writeStrobe_n), .readStrobe_n(readStrobe_n), .resultBusIn(wrData),
        .resultBusOut(resultBusOut), .resultBusOe(resultBusOe), .conversion_done_n(doneN),
        .compareHigh(compareHigh), .muxSel(muxSel), .samplePos(samplePos),
        .sampleNeg(sampleNeg),
        .dacCode(dacCode));

    adc_bus_host u_host (
        .sys_clk(sys_clk), .rdData(resultBusOut), .rdOe(resultBusOe), .doneN(doneN),
        .chipSelect_n(chipSelect_n), .writeStrobe_n(writeStrobe_n),
        .readStrobe_n(readStrobe_n), .wrData(wrData));

    task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic mux_sel_t expSel(input logic [4:0] c);
        mux_sel_t s;
        s = '0;
        if (!c[3]) begin
            s.mode = MODE_DIFF;
            s.posSel[{c[2:1], c[0]}] = 1'b1;
            s.negSel[{c[2:1], !c[0]}] = 1'b1;
        end else begin
            s.mode = c[4] ? MODE_PSEUDO : MODE_SINGLE;
            s.posSel[c[2:0]] = 1'b1;
            s.negSel[7] = c[4];
            s.negGround = !c[4];
        end
        return s;
    endfunction

    task automatic stop_test();
        if (n_errors == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic test_configs();
        for (int c = 0; c < 31; c++) begin
            u_host.access(1'b1, 1'b0, 8'(c), seen);
            check("done after write", 32'(doneN), 32'h1);
            @(posedge sys_clk);
            #10;
            check("mux select", 32'(muxSel), 32'(expSel(5'(c))));
        end
    endtask

    task automatic test_convert();
        u_host.access(1'b1, 1'b0, 8'h0B, seen);
        u_host.waitDone(ok);
        check("done low", 32'(ok), 32'h1);
        target = 8'h3C;
        u_host.access(1'b0, 1'b1, 8'h00, seen);
        check("read data", 32'(seen), 32'hFFA5);
        @(posedge sys_clk);
        check("done cleared", 32'(doneN), 32'h1);
        u_host.waitDone(ok);
        check("done low again", 32'(ok), 32'h1);
        u_host.access(1'b0, 1'b1, 8'h00, seen);
        check("reconvert data", 32'(seen), 32'hFF3C);
        check("config kept", 32'(muxSel), 32'(expSel(5'h0B)));
        u_host.access(1'b1, 1'b0, 8'h1A, seen);
        @(posedge sys_clk);
        #10;
        check("write after read", 32'(muxSel), 32'(expSel(5'h1A)));
        check("plus sample", 32'({samplePos, sampleNeg}), 32'h2);
        repeat (STEP_CYCLES / 2) @(posedge sys_clk);
        #10;
        check("minus sample", 32'({samplePos, sampleNeg}), 32'h1);
        u_host.access(1'b1, 1'b1, 8'h05, seen);
        @(posedge sys_clk);
        #10;
        check("config retained", 32'(muxSel), 32'(expSel(5'h1A)));
        check("old result out", 32'(seen[7:0]), 32'h3C);
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk);
        n_errors++;
        stop_test();
    end

    initial begin
        repeat (16) @(posedge sys_clk);
        #10;
        nrst = 1'b1;
        check("reset done", 32'(doneN), 32'h1);
        check("reset mux", 32'(muxSel), 32'(expSel(5'h00)));
        test_configs();
        test_convert();
        stop_test();
    end
endmodule
